// ---- design/anr_pkg.sv ----
/*
 * anr_pkg: offsets, field layouts, masks, reset values and mode codes
 * shared by the auto-negotiation ability register bank.
 * assumes: byte-wide host bus, one register byte per address.
 */
package anr_pkg;

  // ***************************************************
  // register offsets (byte addresses on the host bus)
  // ***************************************************
  localparam int ADDR_W = 6;
  localparam logic [5:0] OFS_ADV_LO = 6'h08;
  localparam logic [5:0] OFS_ADV_HI = 6'h09;
  localparam logic [5:0] OFS_LP_LO = 6'h0A;
  localparam logic [5:0] OFS_LP_HI = 6'h0B;
  localparam logic [5:0] OFS_EXP_LO = 6'h0C;
  localparam logic [5:0] OFS_EXP_HI = 6'h0D;
  localparam logic [5:0] OFS_EXT_LO = 6'h1E;
  localparam logic [5:0] OFS_EXT_HI = 6'h1F;

  // ***************************************************
  // operating modes
  // ***************************************************
  localparam logic [1:0] MODE_GBE = 2'h0;
  localparam logic [1:0] MODE_SGMII_PHY = 2'h1;
  localparam logic [1:0] MODE_SGMII_MAC = 2'h2;

  // ***************************************************
  // writable / defined bit masks per layout
  // ***************************************************
  // gbe high: next page, ack, remote fault[1:0], pause[1:0]
  localparam logic [7:0] MASK_GBE_HI = 8'hF3;
  // gbe low: half duplex, full duplex
  localparam logic [7:0] MASK_GBE_LO = 8'hC0;
  // sgmii high: link status, ack, duplex, speed[1:0]
  localparam logic [7:0] MASK_SGMII_HI = 8'hDC;
  // sgmii low byte is the constant one at bit 0
  localparam logic [7:0] CONST_SGMII_LO = 8'h01;
  // mac side high byte: acknowledge only
  localparam logic [7:0] CONST_MAC_HI = 8'h40;

  // ***************************************************
  // fixed bytes and field positions
  // ***************************************************
  localparam logic [7:0] CONST_EXT_HI = 8'h80;
  localparam logic [7:0] CONST_ZERO = 8'h00;
  localparam int EXP_PAGE_RX_BIT = 1;

  // ***************************************************
  // reset values of the advertised bytes
  // ***************************************************
  localparam logic [7:0] RST_ADV_HI = 8'h00;
  localparam logic [7:0] RST_ADV_LO = 8'h00;

endpackage

// ---- design/anr_pad_regs.sv ----
/*
 * anr_pad_regs: (g)mii pad flip-flops, one stage each way.
 * assumes: pad inputs are source-synchronous to sys_clk, so one
 * capture flop at the pad suffices and no synchroniser is needed.
 */
`timescale 1ns/1ps
module anr_pad_regs #(
  parameter int DATA_W = 8
) (
  // clock and reset
  input wire logic sys_clk,
  input wire logic rst_b,
  // pad side, inbound
  input wire logic [DATA_W-1:0] pad_txd,
  input wire logic pad_tx_en,
  input wire logic pad_tx_er,
  // core side, inbound
  output logic [DATA_W-1:0] core_txd,
  output logic core_tx_en,
  output logic core_tx_er,
  // core side, outbound
  input wire logic [DATA_W-1:0] core_rxd,
  input wire logic core_rx_dv,
  input wire logic core_rx_er,
  input wire logic core_col,
  input wire logic core_crs,
  // pad side, outbound
  output logic [DATA_W-1:0] pad_rxd,
  output logic pad_rx_dv,
  output logic pad_rx_er,
  output logic pad_col,
  output logic pad_crs
);

  // ***************************************************
  // pad registers
  // ***************************************************
  always_ff @(posedge sys_clk or negedge rst_b) begin
    if (!rst_b) begin
      core_txd <= '0;
      core_tx_en <= 1'b0;
      core_tx_er <= 1'b0;
      pad_rxd <= '0;
      pad_rx_dv <= 1'b0;
      pad_rx_er <= 1'b0;
      pad_col <= 1'b0;
      pad_crs <= 1'b0;
    end else begin
      core_txd <= pad_txd; // see R10
      core_tx_en <= pad_tx_en;
      core_tx_er <= pad_tx_er;
      pad_rxd <= core_rxd; // see R10
      pad_rx_dv <= core_rx_dv;
      pad_rx_er <= core_rx_er;
      pad_col <= core_col;
      pad_crs <= core_crs;
    end
  end

endmodule // anr_pad_regs

// ---- design/anr_ability_regs.sv ----
/*
 * anr_ability_regs: auto-negotiation ability, expansion and extended
 * status bytes of the pcs management map, plus the (g)mii pad flops.
 * assumes: host bus strobes and the negotiation engine inputs are on
 * sys_clk; cfg_mode is static configuration.
 */
`timescale 1ns/1ps

// Contract
// R1 - adv high byte writable in gbe and phy side, layout set by mode
// R2 - adv low byte writable in gbe only; mac side makes both adv bytes constants
// R3 - partner high byte read-only, layout per gbe or sgmii
// R4 - partner low byte read-only; gbe duplex bits, sgmii reads one
// R5 - upper expansion byte always reads zero
// R6 - lower expansion byte: bits 7:3, 2 and 0 read zero
// R7 - page received bit latches on arrival, cleared by host read
// R8 - upper extended status reads 0x80 only
// R9 - lower extended status reads zero
// R10 - (g)mii data passes through pad flip-flops both ways
// R11 - mode picks layout and access; writes to fixed bits ignored
// R12 - host accesses one byte per address
module anr_ability_regs #(
  parameter int DATA_W = 8
) (
  // clock and reset
  input wire logic sys_clk,
  input wire logic rst_b,
  // configuration
  input wire logic [1:0] cfg_mode,
  // host bus
  input wire logic [anr_pkg::ADDR_W-1:0] host_addr,
  input wire logic host_wr,
  input wire logic host_rd,
  input wire logic [7:0] host_wdata,
  output logic [7:0] host_rdata,
  // negotiation engine
  input wire logic [7:0] partner_hi,
  input wire logic [7:0] partner_lo,
  input wire logic page_rx,
  // advertised bytes toward the engine
  output logic [7:0] adv_hi,
  output logic [7:0] adv_lo,
  // (g)mii pads
  input wire logic [DATA_W-1:0] pad_txd,
  input wire logic pad_tx_en,
  input wire logic pad_tx_er,
  output logic [DATA_W-1:0] core_txd,
  output logic core_tx_en,
  output logic core_tx_er,
  input wire logic [DATA_W-1:0] core_rxd,
  input wire logic core_rx_dv,
  input wire logic core_rx_er,
  input wire logic core_col,
  input wire logic core_crs,
  output logic [DATA_W-1:0] pad_rxd,
  output logic pad_rx_dv,
  output logic pad_rx_er,
  output logic pad_col,
  output logic pad_crs
);

  // ***************************************************
  // mode decode
  // ***************************************************
  wire logic mode_gbe;
  wire logic mode_mac;
  wire logic [7:0] adv_hi_mask;
  wire logic [7:0] adv_lo_mask;
  wire logic [7:0] lp_hi_mask;

  assign mode_gbe = (cfg_mode == anr_pkg::MODE_GBE);
  assign mode_mac = (cfg_mode == anr_pkg::MODE_SGMII_MAC);
  // mac side stores nothing: both masks are empty
  assign adv_hi_mask = mode_gbe ? anr_pkg::MASK_GBE_HI :
                       mode_mac ? anr_pkg::CONST_ZERO :
                       anr_pkg::MASK_SGMII_HI; // see R11
  assign adv_lo_mask = mode_gbe ? anr_pkg::MASK_GBE_LO :
                       anr_pkg::CONST_ZERO; // see R11
  assign lp_hi_mask = mode_gbe ? anr_pkg::MASK_GBE_HI :
                      anr_pkg::MASK_SGMII_HI;

  // ***************************************************
  // address decode
  // ***************************************************
  wire logic sel_adv_lo;
  wire logic sel_adv_hi;
  wire logic sel_lp_lo;
  wire logic sel_lp_hi;
  wire logic sel_exp_lo;
  wire logic sel_exp_hi;
  wire logic sel_ext_lo;
  wire logic sel_ext_hi;

  assign sel_adv_lo = (host_addr == anr_pkg::OFS_ADV_LO);
  assign sel_adv_hi = (host_addr == anr_pkg::OFS_ADV_HI);
  assign sel_lp_lo = (host_addr == anr_pkg::OFS_LP_LO);
  assign sel_lp_hi = (host_addr == anr_pkg::OFS_LP_HI);
  assign sel_exp_lo = (host_addr == anr_pkg::OFS_EXP_LO);
  assign sel_exp_hi = (host_addr == anr_pkg::OFS_EXP_HI);
  assign sel_ext_lo = (host_addr == anr_pkg::OFS_EXT_LO);
  assign sel_ext_hi = (host_addr == anr_pkg::OFS_EXT_HI);

  // ***************************************************
  // advertised ability storage
  // ***************************************************
  logic [7:0] adv_hi_q;
  logic [7:0] adv_lo_q;
  logic [7:0] adv_hi_d;
  logic [7:0] adv_lo_d;

  // only the defined bits are stored, so a mode change cannot expose
  // stale bits of another layout
  assign adv_hi_d = (host_wr && sel_adv_hi) ?
                    (host_wdata & adv_hi_mask) : (adv_hi_q & adv_hi_mask);
  assign adv_lo_d = (host_wr && sel_adv_lo) ?
                    (host_wdata & adv_lo_mask) : (adv_lo_q & adv_lo_mask);

  always_ff @(posedge sys_clk or negedge rst_b) begin
    if (!rst_b) begin
      adv_hi_q <= anr_pkg::RST_ADV_HI;
      adv_lo_q <= anr_pkg::RST_ADV_LO;
    end else begin
      adv_hi_q <= adv_hi_d; // see R1
      adv_lo_q <= adv_lo_d; // see R2
    end
  end

  // ***************************************************
  // presented views
  // ***************************************************
  wire logic [7:0] adv_hi_view;
  wire logic [7:0] adv_lo_view;
  wire logic [7:0] lp_hi_view;
  wire logic [7:0] lp_lo_view;
  wire logic [7:0] exp_lo_view;

  assign adv_hi_view = mode_mac ? anr_pkg::CONST_MAC_HI :
                       adv_hi_q; // see R1
  assign adv_lo_view = mode_gbe ? adv_lo_q :
                       anr_pkg::CONST_SGMII_LO; // see R2
  assign lp_hi_view = partner_hi & lp_hi_mask; // see R3
  assign lp_lo_view = mode_gbe ? (partner_lo & anr_pkg::MASK_GBE_LO) :
                      anr_pkg::CONST_SGMII_LO; // see R4
  assign adv_hi = adv_hi_view;
  assign adv_lo = adv_lo_view;

  // ***************************************************
  // page received flag
  // ***************************************************
  logic page_flag_q;
  logic page_flag_d;
  wire logic rd_exp_lo;

  assign rd_exp_lo = host_rd && sel_exp_lo;
  // a page arriving during the clearing read is kept
  assign page_flag_d = page_rx ? 1'b1 :
                       rd_exp_lo ? 1'b0 : page_flag_q; // see R7

  always_ff @(posedge sys_clk or negedge rst_b) begin
    if (!rst_b) begin
      page_flag_q <= 1'b0;
    end else begin
      page_flag_q <= page_flag_d;
    end
  end

  // next page ability and reserved bits stay zero
  assign exp_lo_view = {5'h00, 1'b0, page_flag_q, 1'b0}; // see R6

  // ***************************************************
  // read mux and data register
  // ***************************************************
  logic [7:0] rdata_q;
  logic [7:0] rdata_d;
  wire logic [7:0] rd_mux;

  assign rd_mux = sel_adv_lo ? adv_lo_view :
                  sel_adv_hi ? adv_hi_view :
                  sel_lp_lo ? lp_lo_view :
                  sel_lp_hi ? lp_hi_view :
                  sel_exp_lo ? exp_lo_view :
                  sel_exp_hi ? anr_pkg::CONST_ZERO : // see R5
                  sel_ext_lo ? anr_pkg::CONST_ZERO : // see R9
                  sel_ext_hi ? anr_pkg::CONST_EXT_HI : // see R8
                  anr_pkg::CONST_ZERO;
  // single byte per access; no auto increment across bytes
  assign rdata_d = host_rd ? rd_mux : rdata_q; // see R12

  always_ff @(posedge sys_clk or negedge rst_b) begin
    if (!rst_b) begin
      rdata_q <= anr_pkg::CONST_ZERO;
    end else begin
      rdata_q <= rdata_d;
    end
  end

  assign host_rdata = rdata_q;

  // ***************************************************
  // (g)mii pad flops
  // ***************************************************
  anr_pad_regs #(
    .DATA_W(DATA_W)
  ) u_pads (
    .sys_clk(sys_clk),
    .rst_b(rst_b),
    .pad_txd(pad_txd),
    .pad_tx_en(pad_tx_en),
    .pad_tx_er(pad_tx_er),
    .core_txd(core_txd),
    .core_tx_en(core_tx_en),
    .core_tx_er(core_tx_er),
    .core_rxd(core_rxd),
    .core_rx_dv(core_rx_dv),
    .core_rx_er(core_rx_er),
    .core_col(core_col),
    .core_crs(core_crs),
    .pad_rxd(pad_rxd),
    .pad_rx_dv(pad_rx_dv),
    .pad_rx_er(pad_rx_er),
    .pad_col(pad_col),
    .pad_crs(pad_crs)
  ); // see R10

  // ***************************************************
  // assertions
  // ***************************************************
  default clocking cb @(posedge sys_clk);
  endclocking
  default disable iff (!rst_b);

  property p_adv_hi_wr_gbe;
    logic [7:0] d;
    (host_wr && sel_adv_hi && mode_gbe, d = host_wdata) ##1
      (host_rd && sel_adv_hi && !host_wr && mode_gbe)
      |=> host_rdata == (d & 8'hF3);
  endproperty
  a_adv_hi_wr_gbe: assert property (p_adv_hi_wr_gbe) // see R1
    else $error("adv high byte readback wrong in gbe mode");

  property p_adv_hi_phy_zero;
    host_rd && sel_adv_hi && cfg_mode == anr_pkg::MODE_SGMII_PHY
      |=> (host_rdata & 8'h23) == 8'h00;
  endproperty
  a_adv_hi_phy_zero: assert property (p_adv_hi_phy_zero) // see R1
    else $error("undefined phy side adv high bits not zero");

  property p_adv_sgmii_lo;
    host_rd && sel_adv_lo && !mode_gbe |=> host_rdata == 8'h01;
  endproperty
  a_adv_sgmii_lo: assert property (p_adv_sgmii_lo) // see R2
    else $error("sgmii adv low byte not 0x01");

  property p_mac_hi_const;
    host_rd && sel_adv_hi && mode_mac |=> host_rdata == 8'h40;
  endproperty
  a_mac_hi_const: assert property (p_mac_hi_const) // see R11
    else $error("mac side adv high byte not 0x40");

  property p_lp_hi;
    host_rd && sel_lp_hi |=>
      host_rdata == ($past(partner_hi) &
                     ($past(mode_gbe) ? 8'hF3 : 8'hDC));
  endproperty
  a_lp_hi: assert property (p_lp_hi) // see R3
    else $error("partner high byte layout wrong");

  property p_lp_lo;
    host_rd && sel_lp_lo |=>
      host_rdata == ($past(mode_gbe) ? ($past(partner_lo) & 8'hC0) :
                     8'h01);
  endproperty
  a_lp_lo: assert property (p_lp_lo) // see R4
    else $error("partner low byte layout wrong");

  property p_exp_hi;
    host_rd && sel_exp_hi |=> host_rdata == 8'h00;
  endproperty
  a_exp_hi: assert property (p_exp_hi) // see R5
    else $error("upper expansion byte not zero");

  property p_exp_lo_rsvd;
    host_rd && sel_exp_lo |=> host_rdata[7:2] == 6'h00 &&
                               host_rdata[0] == 1'b0;
  endproperty
  a_exp_lo_rsvd: assert property (p_exp_lo_rsvd) // see R6
    else $error("lower expansion reserved bits not zero");

  property p_page_latch;
    page_rx ##1 (host_rd && sel_exp_lo) |=> host_rdata[1];
  endproperty
  a_page_latch: assert property (p_page_latch) // see R7
    else $error("page received not latched");

  property p_page_clear;
    rd_exp_lo && !page_rx ##1 (host_rd && sel_exp_lo && !page_rx)
      |=> !host_rdata[1];
  endproperty
  a_page_clear: assert property (p_page_clear) // see R7
    else $error("page received not cleared by read");

  property p_ext_hi;
    host_rd && sel_ext_hi |=> host_rdata == 8'h80;
  endproperty
  a_ext_hi: assert property (p_ext_hi) // see R8
    else $error("upper extended status not 0x80");

  property p_ext_lo;
    host_rd && sel_ext_lo |=> host_rdata == 8'h00;
  endproperty
  a_ext_lo: assert property (p_ext_lo) // see R9
    else $error("lower extended status not zero");

  property p_pad_path;
    ##1 1'b1 |-> core_txd == $past(pad_txd) &&
                 pad_rxd == $past(core_rxd) &&
                 pad_rx_dv == $past(core_rx_dv);
  endproperty
  a_pad_path: assert property (p_pad_path) // see R10
    else $error("pad flops not one stage");

  property p_rdata_hold;
    !host_rd |=> $stable(host_rdata);
  endproperty
  a_rdata_hold: assert property (p_rdata_hold) // see R12
    else $error("read data changed without a read");

  c_gbe_write_read: cover property (
    host_wr && sel_adv_hi && mode_gbe ##1 host_rd && sel_adv_hi);
  c_page_clear: cover property (
    page_rx ##[1:4] rd_exp_lo ##1 host_rd && sel_exp_lo);
  c_page_collide: cover property (page_rx && rd_exp_lo);
  c_mac_read: cover property (host_rd && sel_adv_hi && mode_mac);

endmodule // anr_ability_regs

// ---- tb/anr_engine_model.sv ----
/*
 * anr_engine_model: stand-in for the negotiation engine that fills the
 * partner ability bytes and flags each received page.
 * assumes: commanded by the bench on sys_clk, one page per send pulse.
 */
`timescale 1ns/1ps
module anr_engine_model (
  // clock and reset
  input wire logic sys_clk,
  input wire logic rst_b,
  // bench command
  input wire logic send,
  input wire logic [7:0] hi_in,
  input wire logic [7:0] lo_in,
  // toward the register bank
  output logic [7:0] partner_hi,
  output logic [7:0] partner_lo,
  output logic page_rx
);
  // page flag is send registered, high for as many cycles as send was held
  always_ff @(posedge sys_clk or negedge rst_b) begin
    if (!rst_b) begin
      partner_hi <= 8'h00;
      partner_lo <= 8'h00;
      page_rx <= 1'b0;
    end else begin
      page_rx <= send;
      if (send) begin
        partner_hi <= hi_in;
        partner_lo <= lo_in;
      end
    end
  end
endmodule // anr_engine_model

// ---- tb/testbench.sv ----
/*
 * testbench: self-checking bench for anr_ability_regs.
 * assumes: engine model on the partner ports, host bus driven here.
 */
`timescale 1ns/1ps
module testbench;
  localparam int DLY = 1;
  logic sys_clk = 1'b0;
  logic rst_b = 1'b0;
  logic [1:0] cfg_mode = 2'h0;
  logic [5:0] host_addr = 6'h00;
  logic host_wr = 1'b0;
  logic host_rd = 1'b0;
  logic [7:0] host_wdata = 8'h00;
  logic [7:0] host_rdata, adv_hi, adv_lo, partner_hi, partner_lo;
  logic page_rx, send = 1'b0;
  logic [7:0] hi_in = 8'h00;
  logic [7:0] lo_in = 8'h00;
  logic [7:0] pad_txd = 8'h00;
  logic [7:0] core_rxd = 8'h00;
  logic [7:0] core_txd, pad_rxd;
  logic pad_tx_en = 1'b0;
  logic pad_tx_er = 1'b0;
  logic [4:0] core_ctl = 5'h00;
  logic core_tx_en, core_tx_er, pad_rx_dv, pad_rx_er, pad_col, pad_crs;
  int n_mismatch = 0;
  int n_tests = 0;
  // per mode: gbe, phy side, mac side, spare code (acts as phy side)
  logic [7:0] rst_hi [4] = '{8'h00, 8'h00, 8'h40, 8'h00};
  logic [7:0] rst_lo [4] = '{8'h00, 8'h01, 8'h01, 8'h01};
  logic [7:0] wr_hi [4] = '{8'hF3, 8'hDC, 8'h40, 8'hDC};
  logic [7:0] wr_lo [4] = '{8'hC0, 8'h01, 8'h01, 8'h01};
  logic [7:0] lp_hi [4] = '{8'hF3, 8'hDC, 8'hDC, 8'hDC};
  logic [7:0] lp_lo [4] = '{8'hC0, 8'h01, 8'h01, 8'h01};
  // 0x5A written to the high byte, as each layout keeps it
  logic [7:0] bb_hi [4] = '{8'h52, 8'h58, 8'h40, 8'h58};

  always #10 sys_clk = ~sys_clk;

  anr_engine_model u_anr_engine_model (.sys_clk(sys_clk), .rst_b(rst_b),
    .send(send), .hi_in(hi_in), .lo_in(lo_in), .partner_hi(partner_hi),
    .partner_lo(partner_lo), .page_rx(page_rx));

  anr_ability_regs u_anr_ability_regs (.sys_clk(sys_clk), .rst_b(rst_b),
    .cfg_mode(cfg_mode), .host_addr(host_addr), .host_wr(host_wr),
    .host_rd(host_rd), .host_wdata(host_wdata), .host_rdata(host_rdata),
    .partner_hi(partner_hi), .partner_lo(partner_lo), .page_rx(page_rx),
    .adv_hi(adv_hi), .adv_lo(adv_lo), .pad_txd(pad_txd),
    .pad_tx_en(pad_tx_en), .pad_tx_er(pad_tx_er), .core_txd(core_txd),
    .core_tx_en(core_tx_en), .core_tx_er(core_tx_er),
    .core_rxd(core_rxd), .core_rx_dv(core_ctl[4]),
    .core_rx_er(core_ctl[3]), .core_col(core_ctl[2]),
    .core_crs(core_ctl[1]), .pad_rxd(pad_rxd), .pad_rx_dv(pad_rx_dv),
    .pad_rx_er(pad_rx_er), .pad_col(pad_col), .pad_crs(pad_crs));

  // ***************************************************
  // compare and bus tasks
  // ***************************************************
  task automatic chk8(input string what, input logic [7:0] exp,
                      input logic [7:0] got);
    n_tests++;
    if (got !== exp) begin
      n_mismatch++;
      $display("[FAIL] %s expected %h seen %h", what, exp, got);
    end
  endtask

  task automatic chk_pad(input string what, input logic [12:0] exp,
                         input logic [12:0] got);
    n_tests++;
    if (got !== exp) begin
      n_mismatch++;
      $display("[FAIL] %s expected %h seen %h", what, exp, got);
    end
  endtask

  // one byte per access, never a wider word
  task automatic host_write(input logic [5:0] a, input logic [7:0] d);
    @(posedge sys_clk);
    #DLY;
    host_addr = a;
    host_wdata = d;
    host_wr = 1'b1;
    @(posedge sys_clk);
    #DLY;
    host_wr = 1'b0;
  endtask

  task automatic host_read(input logic [5:0] a, output logic [7:0] d);
    @(posedge sys_clk);
    #DLY;
    host_addr = a;
    host_rd = 1'b1;
    @(posedge sys_clk);
    #DLY;
    host_rd = 1'b0;
    d = host_rdata;
  endtask

  // write, then read the same byte in the very next cycle
  task automatic host_wr_rd(input logic [5:0] a, input logic [7:0] wd,
                            output logic [7:0] d);
    @(posedge sys_clk);
    #DLY;
    host_addr = a;
    host_wdata = wd;
    host_wr = 1'b1;
    @(posedge sys_clk);
    #DLY;
    host_wr = 1'b0;
    host_rd = 1'b1;
    @(posedge sys_clk);
    #DLY;
    host_rd = 1'b0;
    d = host_rdata;
  endtask

  // two reads in consecutive cycles; call just after a rising edge
  task automatic host_rd2(input logic [5:0] a, output logic [7:0] d1,
                          output logic [7:0] d2);
    host_addr = a;
    host_rd = 1'b1;
    @(posedge sys_clk);
    #DLY;
    d1 = host_rdata;
    @(posedge sys_clk);
    #DLY;
    host_rd = 1'b0;
    d2 = host_rdata;
  endtask

  // page_rx from the model stands in the cycle in which this returns
  task automatic send_pulse();
    @(posedge sys_clk);
    #DLY;
    send = 1'b1;
    @(posedge sys_clk);
    #DLY;
    send = 1'b0;
  endtask

  task automatic check_reg(input string what, input logic [5:0] a,
                           input logic [7:0] exp);
    logic [7:0] d;
    host_read(a, d);
    chk8(what, exp, d);
  endtask

  task automatic do_reset(input logic [1:0] m);
    @(posedge sys_clk);
    #DLY;
    rst_b = 1'b0;
    cfg_mode = m;
    repeat (6) @(posedge sys_clk);
    #DLY;
    rst_b = 1'b1;
  endtask

  task automatic engine_page(input logic [7:0] h, input logic [7:0] l);
    @(posedge sys_clk);
    #DLY;
    hi_in = h;
    lo_in = l;
    send = 1'b1;
    @(posedge sys_clk);
    #DLY;
    send = 1'b0;
    repeat (2) @(posedge sys_clk);
  endtask

  // ***************************************************
  // scenarios
  // ***************************************************
  task automatic t_mode(input int m);
    logic [7:0] d;
    do_reset(m[1:0]);
    chk8("adv_hi rst", rst_hi[m], adv_hi);
    chk8("adv_lo rst", rst_lo[m], adv_lo);
    engine_page(8'hFF, 8'hFF);
    host_write(6'h09, 8'hFF);
    host_write(6'h08, 8'hFF);
    host_write(6'h1F, 8'h00);
    host_write(6'h0B, 8'h00);
    chk8("adv_hi port", wr_hi[m], adv_hi);
    check_reg("adv hi", 6'h09, wr_hi[m]);
    check_reg("adv lo", 6'h08, wr_lo[m]);
    check_reg("lp hi", 6'h0B, lp_hi[m]);
    check_reg("lp lo", 6'h0A, lp_lo[m]);
    check_reg("exp hi", 6'h0D, 8'h00);
    check_reg("ext lo", 6'h1E, 8'h00);
    check_reg("ext hi", 6'h1F, 8'h80);
    check_reg("unmapped", 6'h3F, 8'h00);
    host_write(6'h09, 8'h00);
    host_write(6'h08, 8'h00);
    check_reg("adv hi clr", 6'h09, rst_hi[m]);
    chk8("adv_lo port", rst_lo[m], adv_lo);
    host_wr_rd(6'h09, 8'h5A, d);
    chk8("adv hi b2b", bb_hi[m], d);
  endtask

  task automatic t_page();
    logic [7:0] d1;
    logic [7:0] d2;
    do_reset(2'h0);
    check_reg("page idle", 6'h0C, 8'h00);
    engine_page(8'h00, 8'h00);
    repeat (3) @(posedge sys_clk);
    check_reg("page set", 6'h0C, 8'h02);
    check_reg("page cleared", 6'h0C, 8'h00);
    // read right after the page, then again at once
    send_pulse();
    @(posedge sys_clk);
    #DLY;
    host_rd2(6'h0C, d1, d2);
    chk8("page next rd", 8'h02, d1);
    chk8("page rd clear", 8'h00, d2);
    // clearing read in the page cycle: the set must win
    send_pulse();
    host_rd2(6'h0C, d1, d2);
    chk8("page collide old", 8'h00, d1);
    chk8("page collide set", 8'h02, d2);
    check_reg("page collide clr", 6'h0C, 8'h00);
  endtask

  task automatic t_pads();
    logic [7:0] v [4] = '{8'h00, 8'hA5, 8'h5A, 8'hFF};
    for (int i = 0; i < 4; i++) begin
      @(posedge sys_clk);
      #DLY;
      pad_txd = v[i];
      {pad_tx_en, pad_tx_er} = i[1:0];
      core_rxd = ~v[i];
      core_ctl = {i[2:0] ^ 3'h5, i[1:0]};
      @(posedge sys_clk);
      #DLY;
      chk_pad("core in", {3'h0, v[i], i[1:0]},
              {3'h0, core_txd, core_tx_en, core_tx_er});
      chk_pad("pad out", {~v[i], i[2:0] ^ 3'h5, i[1:0]},
              {pad_rxd, pad_rx_dv, pad_rx_er, pad_col, pad_crs,
               core_ctl[0]});
    end
  endtask

  // ***************************************************
  // sequence and verdict
  // ***************************************************
  task automatic wrap_up();
    $display("mismatches %0d comparisons %0d", n_mismatch, n_tests);
    if (n_mismatch == 0 && n_tests > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask

  initial begin
    for (int m = 0; m < 4; m++) begin
      t_mode(m);
    end
    t_page();
    t_pads();
    wrap_up();
  end

  // whole run is well under a thousand cycles
  initial begin
    #200000;
    n_mismatch++;
    wrap_up();
  end
endmodule // testbench
